// File: hw/acf_dig_compare.sv
// One digital comparator: checks each new result of an enabled channel
// against low and high thresholds and latches the channel number.
// Assumes results arrive as one-cycle valid strobes on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module acf_dig_compare
    import acf_pkg::*;
#(
    parameter int DW = 12
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cmpOn,
    input wire logic [4:0] condBits,
    input wire logic [15:0] chanEnable,
    input wire logic [DW-1:0] lowThr,
    input wire logic [DW-1:0] highThr,
    input wire logic resValid,
    input wire logic [4:0] resChannel,
    input wire logic [DW-1:0] resData,
    input wire logic chanRead,
    output logic eventStat_r,
    output logic [4:0] eventChan_r,
    output logic eventPulse_r
);
    if (DW < 1 || DW > 16) begin : gBadDw
        $error("acf_dig_compare: DW out of range");
    end

    logic geLow;
    logic geHigh;
    logic hit;

    assign geLow = resData >= lowThr;
    assign geHigh = resData >= highThr;

    always_comb begin
        hit = 1'b0;
        if (condBits[ACF_CMP_COND_BETWEEN] && geLow && !geHigh) begin
            hit = 1'b1;
        end
        if (condBits[ACF_CMP_AHIGH] && geHigh) begin
            hit = 1'b1;
        end
        if (condBits[ACF_CMP_BHIGH] && !geHigh) begin
            hit = 1'b1;
        end
        if (condBits[ACF_CMP_ALOW] && geLow) begin
            hit = 1'b1;
        end
        if (condBits[ACF_CMP_BLOW] && !geLow) begin
            hit = 1'b1;
        end
        // Only enabled, implemented channels are examined
        if (!(cmpOn && resValid && resChannel <= ACF_CHAN_MAX && chanEnable[resChannel[3:0]])) begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            eventStat_r <= 1'b0;
            eventPulse_r <= 1'b0;
        end else begin
            eventPulse_r <= hit;
            if (!cmpOn) begin
                eventStat_r <= 1'b0;
            end else if (hit) begin
                eventStat_r <= 1'b1;
            end else if (chanRead) begin
                eventStat_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            eventChan_r <= 5'h00;
        end else if (hit) begin
            eventChan_r <= resChannel;
        end
    end

endmodule : acf_dig_compare
`default_nettype wire

// File: hw/acf_filter.sv
// Oversampling and averaging filter for one selected channel.
// Assumes results arrive as one-cycle valid strobes on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module acf_filter
    import acf_pkg::*;
#(
    parameter int DW = 12
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic filterOn,
    input wire logic [1:0] mode,
    input wire logic [2:0] ratio,
    input wire logic [4:0] chanSel,
    input wire logic resValid,
    input wire logic [4:0] resChannel,
    input wire logic [DW-1:0] resData,
    input wire logic resultRead,
    output logic [15:0] result_r,
    output logic ready_r,
    output logic donePulse_r
);
    if (DW != 12) begin : gBadDw
        $error("acf_filter: result formats need DW of 12");
    end

    // Log2 of the sample count for a ratio code
    function automatic logic [3:0] sampleLog(input logic [1:0] m, input logic [2:0] r);
        if (m == ACF_FLT_MODE_AVG) begin
            sampleLog = {1'b0, r} + 4'h1;
        end else if (!r[2]) begin
            sampleLog = {r, 1'b0} + 4'h2;
        end else begin
            sampleLog = {r, 1'b0} - 4'h7;
        end
    endfunction : sampleLog

    logic [3:0] lg;
    logic [3:0] shift;
    logic [8:0] target;
    logic [8:0] cnt_r;
    logic [19:0] sum_r;
    logic [19:0] sum_nxt;
    logic take;
    logic last;

    assign lg = sampleLog(mode, ratio);
    assign shift = (mode == ACF_FLT_MODE_AVG) ? lg : {1'b0, lg[3:1]};
    assign target = 9'(9'h001 << lg);
    assign take = filterOn && (mode == ACF_FLT_MODE_OVS || mode == ACF_FLT_MODE_AVG)
                  && resValid && resChannel == chanSel;
    assign sum_nxt = sum_r + {8'h00, resData};
    assign last = (cnt_r + 9'h001) == target;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 9'h000;
            sum_r <= 20'h00000;
            result_r <= ACF_RST_16;
            donePulse_r <= 1'b0;
        end else begin
            donePulse_r <= 1'b0;
            if (!filterOn) begin
                cnt_r <= 9'h000;
                sum_r <= 20'h00000;
            end else if (take) begin
                if (last) begin
                    cnt_r <= 9'h000;
                    sum_r <= 20'h00000;
                    result_r <= 16'(sum_nxt >> shift);
                    donePulse_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 9'h001;
                    sum_r <= sum_nxt;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ready_r <= 1'b0;
        end else if (!filterOn) begin
            ready_r <= 1'b0;
        end else if (take && last) begin
            ready_r <= 1'b1;
        end else if (resultRead) begin
            ready_r <= 1'b0;
        end
    end

endmodule : acf_filter
`default_nettype wire

// File: hw/acf_pkg.sv
// Register map, field positions and reset values of the ADC calibration,
// compare and filter control block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package acf_pkg;

    // Register byte addresses
    localparam logic [7:0] ACF_ADDR_CAL_DED = 8'h00;
    localparam logic [7:0] ACF_ADDR_CAL_SHR = 8'h04;
    localparam logic [7:0] ACF_ADDR_CMP0_CON = 8'h08;
    localparam logic [7:0] ACF_ADDR_CMP0_EN = 8'h0C;
    localparam logic [7:0] ACF_ADDR_CMP0_LO = 8'h10;
    localparam logic [7:0] ACF_ADDR_CMP0_HI = 8'h14;
    localparam logic [7:0] ACF_ADDR_CMP1_CON = 8'h18;
    localparam logic [7:0] ACF_ADDR_CMP1_EN = 8'h1C;
    localparam logic [7:0] ACF_ADDR_CMP1_LO = 8'h20;
    localparam logic [7:0] ACF_ADDR_CMP1_HI = 8'h24;
    localparam logic [7:0] ACF_ADDR_FLT_CON = 8'h28;
    localparam logic [7:0] ACF_ADDR_FLT_DAT = 8'h2C;

    // AXI responses
    localparam logic [1:0] ACF_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACF_RESP_SLVERR = 2'h2;

    // Calibration field offsets inside a core's byte, and the core bases
    localparam int ACF_CAL_START = 0;
    localparam int ACF_CAL_EN = 1;
    localparam int ACF_CAL_DIFF = 2;
    localparam int ACF_CAL_BYP = 3;
    localparam int ACF_CAL_RDY = 7;
    localparam int ACF_CAL_CORE0_BASE = 0;
    localparam int ACF_CAL_CORE1_BASE = 8;
    localparam int ACF_CAL_SHR_BASE = 8;
    localparam int ACF_CAL_CORES = 3;

    // Comparator control fields
    localparam int ACF_CMP_CHNL_LSB = 8;
    localparam int ACF_CMP_ON = 7;
    localparam int ACF_CMP_IE = 6;
    localparam int ACF_CMP_STAT = 5;
    localparam int ACF_CMP_COND_BETWEEN = 4;
    localparam int ACF_CMP_AHIGH = 3;
    localparam int ACF_CMP_BHIGH = 2;
    localparam int ACF_CMP_ALOW = 1;
    localparam int ACF_CMP_BLOW = 0;
    localparam logic [15:0] ACF_CMP_CHEN_MASK = 16'h4FFF;
    localparam logic [4:0] ACF_CHAN_MAX = 5'h0E;

    // Filter control fields
    localparam int ACF_FLT_ON = 15;
    localparam int ACF_FLT_MODE_LSB = 13;
    localparam int ACF_FLT_RATIO_LSB = 10;
    localparam int ACF_FLT_IE = 9;
    localparam int ACF_FLT_RDY = 8;
    localparam logic [15:0] ACF_FLT_WR_MASK = 16'hFE1F;
    localparam logic [1:0] ACF_FLT_MODE_OVS = 2'h0;
    localparam logic [1:0] ACF_FLT_MODE_AVG = 2'h3;

    // Reset values
    localparam logic [15:0] ACF_RST_16 = 16'h0000;
    localparam logic [2:0] ACF_RST_CAL_BUSY = 3'h7;

endpackage : acf_pkg

// File: hw/acf_top.sv
// ADC calibration control, two digital comparators and the result filter,
// with an AXI4-Lite register slave.
// Assumes ADC cores deliver results as one-cycle strobes on sys_clk and run
// calibration while calActive is high.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each dedicated core's done flag reads one when calibrated, zero while calibrating.
// - Bypass bit set skips the power-up calibration; clear calibrates automatically.
// - Differential bit picks differential or single-ended input during calibration.
// - Access-enable bit gates software access to ready, bypass, mode and start.
// - Writing start begins calibration; hardware clears start when calibration ends.
// - Core 0 uses the same bits at positions 7, 3, 2, 1, 0.
// - Shared core bits sit at 15, 11..8 of its own register; low byte zero.
// - Comparator event stores the triggering channel number in a 5-bit field.
// - Comparator works only when enabled; disabling clears its status flag.
// - Comparator interrupt-enable lets each event raise the common interrupt.
// - Status flag sets on event, clears when the channel field is read.
// - Between condition: low threshold <= result < high threshold.
// - High conditions: result at or above, or below, the high threshold.
// - Low conditions: result at or above, or below, the low threshold.
// - Only channels with their enable bit set are compared; 12, 13 and 15 absent.
// - Filter runs only while enabled; disabling clears its ready flag.
// - Oversampling ratios 4x..256x and 2x..128x give 12.1 to 12.4 results.
// - Averaging ratios 2x to 256x give a 12-bit result.
// - Filter interrupt-enable raises the common interrupt when a result is ready.
// - Ready flag sets on new result, clears when the result is read.
module acf_top
    import acf_pkg::*;
#(
    parameter int CAL_CYCLES = 256
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] calBypassStrap,
    output logic [2:0] calActive,
    output logic [2:0] calDiffMode,
    input wire logic resValid,
    input wire logic [4:0] resChannel,
    input wire logic [11:0] resData,
    output logic adcIrq_r
);
    if (CAL_CYCLES < 2 || CAL_CYCLES > 65535) begin : gBadCal
        $error("acf_top: CAL_CYCLES out of range");
    end

    localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        mergeLow[7:0] = s[0] ? d[7:0] : old[7:0];
        mergeLow[15:8] = s[1] ? d[15:8] : old[15:8];
    endfunction : mergeLow

    function automatic logic mapped(input logic [7:0] a);
        mapped = a[1:0] == 2'h0 && a <= ACF_ADDR_FLT_DAT;
    endfunction : mapped

    // Write channel
    logic [7:0] wAddr_r;
    logic awHave_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wHave_r;
    logic wrDo;

    assign s_axi_awready = !awHave_r && !s_axi_bvalid;
    assign s_axi_wready = !wHave_r && !s_axi_bvalid;
    assign wrDo = awHave_r && wHave_r && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            wAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ACF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                wAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (wrDo) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wAddr_r) ? ACF_RESP_OKAY : ACF_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Calibration control
    logic [2:0] calBypass_r;
    logic [2:0] calDiff_r;
    logic [2:0] calEn_r;
    logic [2:0] calStart_r;
    logic [2:0] calBusy_r;
    logic [15:0] calCnt_r [ACF_CAL_CORES];
    logic strapTaken_r;
    logic [2:0] calWr;
    logic [3:0] calFld [ACF_CAL_CORES];
    logic [7:0] calView [ACF_CAL_CORES];

    always_comb begin
        calWr[0] = wrDo && wAddr_r == ACF_ADDR_CAL_DED && wStrb_r[0];
        calWr[1] = wrDo && wAddr_r == ACF_ADDR_CAL_DED && wStrb_r[1];
        calWr[2] = wrDo && wAddr_r == ACF_ADDR_CAL_SHR && wStrb_r[1];
        calFld[0] = wData_r[ACF_CAL_CORE0_BASE +: 4];
        calFld[1] = wData_r[ACF_CAL_CORE1_BASE +: 4];
        calFld[2] = wData_r[ACF_CAL_SHR_BASE +: 4];
        for (int i = 0; i < ACF_CAL_CORES; i++) begin
            // Gated bits read zero while access is disabled
            calView[i] = {!calBusy_r[i] && calEn_r[i], 3'h0, calBypass_r[i] && calEn_r[i],
                          calDiff_r[i] && calEn_r[i], calEn_r[i], calStart_r[i] && calEn_r[i]};
        end
    end

    assign calActive = calBusy_r;
    assign calDiffMode = calDiff_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strapTaken_r <= 1'b0;
            calBypass_r <= 3'h0;
            calDiff_r <= 3'h0;
            calEn_r <= 3'h0;
            calStart_r <= 3'h0;
            calBusy_r <= ACF_RST_CAL_BUSY;
            for (int i = 0; i < ACF_CAL_CORES; i++) begin
                calCnt_r[i] <= 16'h0000;
            end
        end else if (!strapTaken_r) begin
            strapTaken_r <= 1'b1;
            calBypass_r <= calBypassStrap;
            calBusy_r <= ~calBypassStrap;
        end else begin
            for (int i = 0; i < ACF_CAL_CORES; i++) begin
                if (calBusy_r[i]) begin
                    if (calCnt_r[i] == CAL_LAST) begin
                        calBusy_r[i] <= 1'b0;
                        calStart_r[i] <= 1'b0;
                        calCnt_r[i] <= 16'h0000;
                    end else begin
                        calCnt_r[i] <= calCnt_r[i] + 16'h0001;
                    end
                end
                if (calWr[i]) begin
                    calEn_r[i] <= calFld[i][ACF_CAL_EN];
                    if (calFld[i][ACF_CAL_EN]) begin
                        calBypass_r[i] <= calFld[i][ACF_CAL_BYP];
                        calDiff_r[i] <= calFld[i][ACF_CAL_DIFF];
                        if (calFld[i][ACF_CAL_START] && !calBusy_r[i]) begin
                            calStart_r[i] <= 1'b1;
                            calBusy_r[i] <= 1'b1;
                            calCnt_r[i] <= 16'h0000;
                        end
                    end
                end
            end
        end
    end

    // Comparator and filter registers
    logic [7:0] cmpCtl_r [2];
    logic [15:0] cmpChEn_r [2];
    logic [11:0] cmpLo_r [2];
    logic [11:0] cmpHi_r [2];
    logic [15:0] fltCtl_r;
    logic [7:0] aCon [2];
    logic [7:0] aEn [2];
    logic [7:0] aLo [2];
    logic [7:0] aHi [2];

    assign aCon = '{ACF_ADDR_CMP0_CON, ACF_ADDR_CMP1_CON};
    assign aEn = '{ACF_ADDR_CMP0_EN, ACF_ADDR_CMP1_EN};
    assign aLo = '{ACF_ADDR_CMP0_LO, ACF_ADDR_CMP1_LO};
    assign aHi = '{ACF_ADDR_CMP0_HI, ACF_ADDR_CMP1_HI};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 2; i++) begin
                cmpCtl_r[i] <= 8'h00;
                cmpChEn_r[i] <= ACF_RST_16;
                cmpLo_r[i] <= 12'h000;
                cmpHi_r[i] <= 12'h000;
            end
            fltCtl_r <= ACF_RST_16;
        end else if (wrDo) begin
            for (int i = 0; i < 2; i++) begin
                if (wAddr_r == aCon[i] && wStrb_r[0]) begin
                    cmpCtl_r[i] <= wData_r[7:0];
                end
                if (wAddr_r == aEn[i]) begin
                    cmpChEn_r[i] <= mergeLow(cmpChEn_r[i], wData_r, wStrb_r) & ACF_CMP_CHEN_MASK;
                end
                if (wAddr_r == aLo[i]) begin
                    cmpLo_r[i] <= 12'(mergeLow({4'h0, cmpLo_r[i]}, wData_r, wStrb_r));
                end
                if (wAddr_r == aHi[i]) begin
                    cmpHi_r[i] <= 12'(mergeLow({4'h0, cmpHi_r[i]}, wData_r, wStrb_r));
                end
            end
            if (wAddr_r == ACF_ADDR_FLT_CON) begin
                fltCtl_r <= mergeLow(fltCtl_r, wData_r, wStrb_r) & ACF_FLT_WR_MASK;
            end
        end
    end

    // Read channel
    logic [7:0] rAddr;
    logic rdTake;
    logic [1:0] chanRead;
    logic fltRead;
    logic [1:0] cmpStat;
    logic [4:0] cmpChan [2];
    logic [1:0] cmpEvent;
    logic [15:0] fltResult;
    logic fltReady;
    logic fltDone;
    logic [15:0] rdVal;

    assign s_axi_arready = !s_axi_rvalid;
    assign rdTake = s_axi_arvalid && s_axi_arready;
    assign rAddr = s_axi_araddr;
    assign chanRead[0] = rdTake && rAddr == ACF_ADDR_CMP0_CON;
    assign chanRead[1] = rdTake && rAddr == ACF_ADDR_CMP1_CON;
    assign fltRead = rdTake && rAddr == ACF_ADDR_FLT_DAT;

    always_comb begin
        rdVal = 16'h0000;
        case (rAddr)
            ACF_ADDR_CAL_DED: rdVal = {calView[1], calView[0]};
            ACF_ADDR_CAL_SHR: rdVal = {calView[2], 8'h00};
            ACF_ADDR_FLT_CON: rdVal = fltCtl_r | (16'(fltReady) << ACF_FLT_RDY);
            ACF_ADDR_FLT_DAT: rdVal = fltResult;
            default: begin
                for (int i = 0; i < 2; i++) begin
                    if (rAddr == aCon[i]) begin
                        rdVal = {3'h0, cmpChan[i], cmpCtl_r[i][7:6], cmpStat[i], cmpCtl_r[i][4:0]};
                    end
                    if (rAddr == aEn[i]) begin
                        rdVal = cmpChEn_r[i];
                    end
                    if (rAddr == aLo[i]) begin
                        rdVal = {4'h0, cmpLo_r[i]};
                    end
                    if (rAddr == aHi[i]) begin
                        rdVal = {4'h0, cmpHi_r[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ACF_RESP_OKAY;
        end else if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rdVal};
            s_axi_rresp <= mapped(rAddr) ? ACF_RESP_OKAY : ACF_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Two comparators
    for (genvar g = 0; g < 2; g++) begin : gCmp
        acf_dig_compare #(
            .DW(12)
        ) uCmp (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .cmpOn(cmpCtl_r[g][ACF_CMP_ON]),
            .condBits(cmpCtl_r[g][4:0]),
            .chanEnable(cmpChEn_r[g]),
            .lowThr(cmpLo_r[g]),
            .highThr(cmpHi_r[g]),
            .resValid(resValid),
            .resChannel(resChannel),
            .resData(resData),
            .chanRead(chanRead[g]),
            .eventStat_r(cmpStat[g]),
            .eventChan_r(cmpChan[g]),
            .eventPulse_r(cmpEvent[g])
        );
    end

    acf_filter #(
        .DW(12)
    ) uFlt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .filterOn(fltCtl_r[ACF_FLT_ON]),
        .mode(fltCtl_r[ACF_FLT_MODE_LSB +: 2]),
        .ratio(fltCtl_r[ACF_FLT_RATIO_LSB +: 3]),
        .chanSel(fltCtl_r[4:0]),
        .resValid(resValid),
        .resChannel(resChannel),
        .resData(resData),
        .resultRead(fltRead),
        .result_r(fltResult),
        .ready_r(fltReady),
        .donePulse_r(fltDone)
    );

    // Common interrupt pulse
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            adcIrq_r <= 1'b0;
        end else begin
            adcIrq_r <= (cmpEvent[0] && cmpCtl_r[0][ACF_CMP_IE])
                        || (cmpEvent[1] && cmpCtl_r[1][ACF_CMP_IE])
                        || (fltDone && fltCtl_r[ACF_FLT_IE]);
        end
    end

endmodule : acf_top
`default_nettype wire

// File: verification/acf_adc_model.sv
// ADC core model: hands results to the block as one-cycle strobes.
// Assumes the bench calls send from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module acf_adc_model (
    input wire logic sys_clk,
    output logic resValid = 1'h0,
    output logic [4:0] resChannel = 5'h00,
    output logic [11:0] resData = 12'h000
);
    task automatic send(input logic [4:0] c, input logic [11:0] d);
        @(posedge sys_clk);
        resValid <= 1'h1;
        resChannel <= c;
        resData <= d;
        @(posedge sys_clk);
        resValid <= 1'h0;
        resChannel <= ~c;
        resData <= ~d;
    endtask : send
endmodule : acf_adc_model
`default_nettype wire

// File: verification/acf_chk.sv
// Port checker for acf_top: bus handshakes, results and calibration.
// Bound to every acf_top instance.
`timescale 1ns/1ps
`default_nettype none
module acf_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [2:0] calActive,
    input wire logic resValid,
    input wire logic adcIrq_r
);
    localparam int CAL_MAX = 1000;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    AST_RD_ANSWER: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata moved");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half set");
    AST_IRQ_CAUSE: assert property (adcIrq_r |-> $past(resValid, 2))
        else $error("irq without result");
    AST_CAL_END: assert property ($rose(calActive[1]) |-> ##[1:CAL_MAX] !calActive[1])
        else $error("calibration stuck");
endmodule : acf_chk
bind acf_top acf_chk chk_u (.*);
`default_nettype wire

// File: verification/tb_adc_calibration_compare_filter.sv
// Testbench for acf_top: register bus tasks and scenario tasks.
// Assumes acf_top with CAL_CYCLES shortened to 4.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_calibration_compare_filter
    import acf_pkg::*;
();
    logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, resValid, adcIrq_r;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] calBypassStrap = 3'h4, calActive, calDiffMode;
    logic [4:0] resChannel;
    logic [11:0] resData;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, nIrq = 0;
    acf_top #(.CAL_CYCLES(4)) dut_u (.*);
    acf_adc_model adc_u (.*);
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (adcIrq_r === 1'h1) nIrq <= nIrq + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 0, tw = 0;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ta && tw)) begin
            @(posedge sys_clk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, ACF_RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = ACF_RESP_OKAY);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk({s_axi_rresp, s_axi_rdata[29:0]}, {r, e[29:0]});
    endtask : rd
    task automatic t_cal();
        chk({29'h0, calActive}, 32'h3);
        rd(ACF_ADDR_CAL_DED, 32'h0);
        rd(8'h30, 32'h0, ACF_RESP_SLVERR);
        repeat (8) @(posedge sys_clk);
        wr(ACF_ADDR_CAL_DED, 32'h0706);
        #1;
        chk({26'h0, calActive, calDiffMode}, 32'h13);
        repeat (8) @(posedge sys_clk);
        rd(ACF_ADDR_CAL_DED, 32'h8686);
    endtask : t_cal
    task automatic t_cmp();
        wr(ACF_ADDR_CMP0_EN, 32'h4000);
        wr(ACF_ADDR_CMP0_LO, 32'h100);
        wr(ACF_ADDR_CMP0_HI, 32'h200);
        wr(ACF_ADDR_CMP0_CON, 32'hD0);
        adc_u.send(5'h0E, 12'h100);
        rd(ACF_ADDR_CMP0_CON, 32'h0EF0);
        rd(ACF_ADDR_CMP0_CON, 32'h0ED0);
        adc_u.send(5'h0E, 12'h200);
        adc_u.send(5'h0D, 12'h150);
        rd(ACF_ADDR_CMP0_CON, 32'h0ED0);
        for (int i = 0; i < 4; i++) begin
            wr(ACF_ADDR_CMP0_CON, 32'h80 | (32'h8 >> i));
            adc_u.send(5'h0E, 12'h200);
            rd(ACF_ADDR_CMP0_CON, 32'h0E80 | (32'h8 >> i) | (i[0] ? 32'h0 : 32'h20));
        end
        wr(ACF_ADDR_CMP0_CON, 32'h88);
        adc_u.send(5'h0E, 12'h300);
        wr(ACF_ADDR_CMP0_CON, 32'h08);
        rd(ACF_ADDR_CMP0_CON, 32'h0E08);
        chk(nIrq, 32'h1);
    endtask : t_cmp
    task automatic t_flt();
        wr(ACF_ADDR_FLT_CON, 32'hE203);
        adc_u.send(5'h03, 12'h100);
        adc_u.send(5'h05, 12'hFFF);
        adc_u.send(5'h03, 12'h102);
        rd(ACF_ADDR_FLT_CON, 32'hE303);
        rd(ACF_ADDR_FLT_DAT, 32'h101);
        rd(ACF_ADDR_FLT_CON, 32'hE203);
        chk(nIrq, 32'h2);
        wr(ACF_ADDR_FLT_CON, 32'h9003);
        adc_u.send(5'h03, 12'h100);
        adc_u.send(5'h03, 12'h101);
        rd(ACF_ADDR_FLT_DAT, 32'h201);
        wr(ACF_ADDR_FLT_CON, 32'hB003);
        adc_u.send(5'h03, 12'h100);
        adc_u.send(5'h03, 12'h101);
        rd(ACF_ADDR_FLT_CON, 32'hB003);
        wr(ACF_ADDR_FLT_CON, 32'h1003);
        rd(ACF_ADDR_FLT_CON, 32'h1003);
    endtask : t_flt
    task automatic wrap_up();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_cal();
        t_cmp();
        t_flt();
        wrap_up();
    end
endmodule : tb_adc_calibration_compare_filter
`default_nettype wire
